/* File: hw/pmcs_pkg.sv */
// shared constants for the power mode clock selector
// assumes a 10 MHz system clock and a 32-bit avalon-mm register bus
package pmcs_pkg;
   // register byte offsets
   localparam logic [3:0] PMCS_OFS_MODE  = 4'h0;
   localparam logic [3:0] PMCS_OFS_SAVE  = 4'h4;
   // mode control field positions
   localparam int PMCS_B_SLOW_ON  = 7;
   localparam int PMCS_B_FAST_ON  = 6;
   localparam int PMCS_B_IT_SLOW  = 5;
   localparam int PMCS_B_CORE_SL  = 4;
   localparam int PMCS_B_RSVD     = 3;
   localparam logic [7:0] PMCS_MODE_RST = 8'h40;
   // legal upper nibbles, in chain order
   localparam logic [3:0] PMCS_ST_HS   = 4'h4;
   localparam logic [3:0] PMCS_ST_HSDC = 4'hc;
   localparam logic [3:0] PMCS_ST_DC   = 4'he;
   localparam logic [3:0] PMCS_ST_DCLS = 4'hf;
   localparam logic [3:0] PMCS_ST_LS   = 4'hb;
   localparam logic [2:0] PMCS_POS_BAD = 3'h7;
   // operating mode codes
   localparam logic [1:0] PMCS_M_HIGH = 2'h0;
   localparam logic [1:0] PMCS_M_DUAL = 2'h1;
   localparam logic [1:0] PMCS_M_LOW  = 2'h2;
   // power save control and status bits
   localparam int PMCS_B_HALT_REQ = 0;
   localparam int PMCS_B_IDLE_REQ = 1;
   // dead time between core clock gates
   localparam int PMCS_CLK_HZ      = 10000000;
   localparam int PMCS_GAP_NS      = 200;
   localparam int PMCS_GAP_CYC     =
      (PMCS_GAP_NS * (PMCS_CLK_HZ / 1000000) + 999) / 1000;
   localparam logic [3:0] PMCS_GAP_LOAD = 4'(PMCS_GAP_CYC);

   // position in the transition chain, bad for illegal nibbles
   function automatic logic [2:0] pmcs_chain_pos(input logic [3:0] n);
      unique case (n)
         PMCS_ST_HS:   pmcs_chain_pos = 3'h0;
         PMCS_ST_HSDC: pmcs_chain_pos = 3'h1;
         PMCS_ST_DC:   pmcs_chain_pos = 3'h2;
         PMCS_ST_DCLS: pmcs_chain_pos = 3'h3;
         PMCS_ST_LS:   pmcs_chain_pos = 3'h4;
         default:      pmcs_chain_pos = PMCS_POS_BAD;
      endcase
   endfunction

   // operating mode from idle timer select and core select
   function automatic logic [1:0] pmcs_mode(input logic it_sl,
                                            input logic core_sl);
      if (core_sl)
         pmcs_mode = PMCS_M_LOW;
      else if (it_sl)
         pmcs_mode = PMCS_M_DUAL;
      else
         pmcs_mode = PMCS_M_HIGH;
   endfunction
endpackage

/* File: hw/pmcs_sel_if.sv */
// core clock select handshake between controller and clock switch
// assumes both ends share one clock
`timescale 1ns/1ps
`default_nettype none
interface pmcs_sel_if;
   logic want_slow;
   logic fast_gate;
   logic slow_gate;
   logic busy;
   modport sw  (input want_slow, output fast_gate, slow_gate, busy);
   modport ctl (output want_slow, input fast_gate, slow_gate, busy);
endinterface
`default_nettype wire

/* File: hw/pmcs_clk_switch.sv */
// break-before-make gate control for the core clock source
// assumes want_slow comes from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module pmcs_clk_switch
   import pmcs_pkg::*;
(
   input  wire logic clock_i,
   input  wire logic rst_b_i,
   pmcs_sel_if.sw    sel
);
   typedef enum logic [2:0] {
      SW_FAST = 3'b001,
      SW_GAP  = 3'b010,
      SW_SLOW = 3'b100
   } pmcs_sw_t;

   pmcs_sw_t   state;
   pmcs_sw_t   next_state;
   logic [3:0] gap_cnt;
   logic       gap_done;

   assign gap_done = (gap_cnt == 4'h0);

   // both gates closed for the whole gap, so no runt pulse
   always_comb
   begin
      next_state = state;
      unique case (state)
         SW_FAST: if (sel.want_slow) next_state = SW_GAP;
         SW_SLOW: if (!sel.want_slow) next_state = SW_GAP;
         SW_GAP:  if (gap_done)
                     next_state = sel.want_slow ? SW_SLOW : SW_FAST;
      endcase
   end

   always_ff @(posedge clock_i)
   begin
      if (!rst_b_i)
      begin
         state   <= SW_FAST;
         gap_cnt <= 4'h0;
      end
      else
      begin
         state   <= next_state;
         gap_cnt <= (state != SW_GAP) ? PMCS_GAP_LOAD - 4'h1
                    : gap_cnt - {3'h0, !gap_done};
      end
   end

   assign sel.fast_gate = state[0];
   assign sel.slow_gate = state[2];
   assign sel.busy      = state[1];

   a_gates_exclusive: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      !(sel.fast_gate && sel.slow_gate))
      else $error("both core clock gates open");

   a_gap_before_open: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      $rose(sel.slow_gate) || $rose(sel.fast_gate) |->
      $past(sel.busy, 1) && $past(sel.busy, 2))
      else $error("gate opened without dead time");
endmodule
`default_nettype wire

/* File: hw/pmcs_top.sv */
// power mode clock selector: mode register, oscillator enables,
// core clock source and halt / idle power save control
// assumes an avalon-mm master on clock_i; wake and option are pins
// Operation
// - reset loads mode register with 40 hex
// - bit 7 turns the slow oscillator on
// - bit 6 turns the fast oscillator on
// - bit 5 picks slow clock for the idle timer
// - bit 4 gates slow clock to the core
// - mode decode; invalid pair forces low speed
// - bits 2..0 pass unchanged to the idle timer window
// - upper nibble holds only the five legal values
// - legal values form a chain, moves only between neighbours
// - non-adjacent writes are ignored, register unchanged
// - halt and idle exist in every operating mode
// - halt only when option bit allows; halt stops everything
// - idle keeps oscillator, idle timer and monitor running
// - power save keeps all state and other timers frozen
// - any reset returns to high speed mode
//
// The implementer's own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module pmcs_top
   import pmcs_pkg::*;
(
   input  wire logic        clock_i,
   input  wire logic        rst_b_i,
   // avalon-mm slave
   input  wire logic [3:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic [31:0]      avs_readdata_o,
   output logic             avs_waitrequest_o,
   // pins and neighbours
   input  wire logic        halt_option_i,
   input  wire logic        wake_i,
   input  wire logic        idle_tick_i,
   output logic             slow_osc_on_o,
   output logic             fast_osc_on_o,
   output logic             idle_timer_slow_select_o,
   output logic             idle_timer_run_o,
   output logic [2:0]       idle_window_sel_o,
   output logic             core_fast_gate_o,
   output logic             core_slow_gate_o,
   output logic             core_run_o,
   output logic [1:0]       op_mode_o
);
   typedef enum logic [2:0] {
      PS_RUN  = 3'b001,
      PS_IDLE = 3'b010,
      PS_HALT = 3'b100
   } pmcs_ps_t;

   pmcs_sel_if sel ();

   logic [7:0] power_mode_control;
   pmcs_ps_t   ps_state;
   pmcs_ps_t   next_ps_state;
   logic [1:0] opt_sync;
   logic [1:0] wake_sync;
   logic       wake_seen;

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers, first stage read only by the second

   always_ff @(posedge clock_i)
   begin
      if (!rst_b_i)
      begin
         opt_sync  <= 2'h0;
         wake_sync <= 2'h0;
      end
      else
      begin
         opt_sync  <= {opt_sync[0], halt_option_i};
         wake_sync <= {wake_sync[0], wake_i};
      end
   end

   assign wake_seen = wake_sync[1];

   ////////////////////////////////////////////////////////////////////
   // bus decode

   wire        req        = avs_read_i | avs_write_i;
   wire        take       = req & ~avs_waitrequest_o;
   wire        hit_mode   = (avs_address_i == PMCS_OFS_MODE);
   wire        hit_save   = (avs_address_i == PMCS_OFS_SAVE);
   wire        wr_commit  = take & avs_write_i;
   wire        wr_mode    = wr_commit & hit_mode & avs_byteenable_i[0];
   wire        wr_save    = wr_commit & hit_save & avs_byteenable_i[0];
   wire [7:0]  wdata      = avs_writedata_i[7:0];

   // chain positions of old and requested nibble
   wire [2:0]  pos_old    = pmcs_chain_pos(power_mode_control[7:4]);
   wire [2:0]  pos_new    = pmcs_chain_pos(wdata[7:4]);
   wire        step_ok    = (pos_new != PMCS_POS_BAD) &&
                            ((pos_new == pos_old) ||
                             (pos_new == pos_old + 3'h1) ||
                             (pos_old == pos_new + 3'h1));
   // reserved bit is stored as zero whatever is written
   wire [7:0]  next_mode  = {wdata[7:4], 1'b0, wdata[2:0]};

   // decoded operating mode, invalid pair reads as low
   wire [1:0]  mode_now   = pmcs_mode(power_mode_control[PMCS_B_IT_SLOW],
                                      power_mode_control[PMCS_B_CORE_SL]);

   wire [7:0]  save_stat  = {1'b0, opt_sync[1], sel.busy,
                             sel.slow_gate, mode_now,
                             ps_state == PS_IDLE, ps_state == PS_HALT};
   wire [31:0] next_rdata = hit_mode ? {24'h0, power_mode_control}
                          : hit_save ? {24'h0, save_stat}
                          : 32'h0;

   ////////////////////////////////////////////////////////////////////
   // bus answer: waitrequest drops one cycle after the request

   always_ff @(posedge clock_i)
   begin
      if (!rst_b_i)
      begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o    <= 32'h0;
      end
      else
      begin
         avs_waitrequest_o <= ~(req & avs_waitrequest_o);
         if (req & avs_waitrequest_o)
            avs_readdata_o <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // mode register; an illegal step leaves it untouched

   always_ff @(posedge clock_i)
   begin
      if (!rst_b_i)
         power_mode_control <= PMCS_MODE_RST;
      else if (wr_mode && step_ok)
         power_mode_control <= next_mode;
   end

   ////////////////////////////////////////////////////////////////////
   // power save state, same behaviour in every operating mode

   wire halt_req = wr_save & wdata[PMCS_B_HALT_REQ];
   wire idle_req = wr_save & wdata[PMCS_B_IDLE_REQ];

   // halt is refused without the option bit
   always_comb
   begin
      next_ps_state = ps_state;
      unique case (ps_state)
         PS_RUN:
         begin
            if (halt_req && opt_sync[1])
               next_ps_state = PS_HALT;
            else if (idle_req)
               next_ps_state = PS_IDLE;
         end
         PS_IDLE: if (idle_tick_i || wake_seen) next_ps_state = PS_RUN;
         PS_HALT: if (wake_seen) next_ps_state = PS_RUN;
      endcase
   end

   always_ff @(posedge clock_i)
   begin
      if (!rst_b_i)
         ps_state <= PS_RUN;
      else
         ps_state <= next_ps_state;
   end

   ////////////////////////////////////////////////////////////////////
   // core clock source handshake

   // core select goes through the switch
   assign sel.want_slow = power_mode_control[PMCS_B_CORE_SL] |
                          (mode_now == PMCS_M_LOW);

   pmcs_clk_switch u_switch (
      .clock_i (clock_i),
      .rst_b_i (rst_b_i),
      .sel     (sel)
   );

   ////////////////////////////////////////////////////////////////////
   // registered outputs; halt drops every enable, idle keeps clocks

   wire halted = (next_ps_state == PS_HALT);

   // core held in power save, no state is cleared
   always_ff @(posedge clock_i)
   begin
      if (!rst_b_i)
      begin
         slow_osc_on_o            <= 1'b0;
         fast_osc_on_o            <= 1'b1;
         idle_timer_slow_select_o <= 1'b0;
         idle_timer_run_o         <= 1'b1;
         idle_window_sel_o        <= 3'h0;
         core_fast_gate_o         <= 1'b1;
         core_slow_gate_o         <= 1'b0;
         core_run_o               <= 1'b1;
         op_mode_o                <= PMCS_M_HIGH;
      end
      else
      begin
         slow_osc_on_o    <= power_mode_control[PMCS_B_SLOW_ON] & ~halted;
         fast_osc_on_o    <= power_mode_control[PMCS_B_FAST_ON] & ~halted;
         idle_timer_slow_select_o <= power_mode_control[PMCS_B_IT_SLOW] |
                                     (mode_now == PMCS_M_LOW);
         idle_timer_run_o <= ~halted;
         idle_window_sel_o <= power_mode_control[2:0];
         core_fast_gate_o  <= sel.fast_gate & ~halted;
         core_slow_gate_o  <= sel.slow_gate & ~halted;
         core_run_o        <= (next_ps_state == PS_RUN);
         op_mode_o         <= mode_now;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks

   sequence s_mode_write;
      wr_mode && !step_ok;
   endsequence

   a_reset_value: assert property (
      @(posedge clock_i)
      !rst_b_i |=> power_mode_control == PMCS_MODE_RST)
      else $error("mode register not 40 hex after reset");

   a_nibble_legal: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      pmcs_chain_pos(power_mode_control[7:4]) != PMCS_POS_BAD)
      else $error("illegal upper nibble held");

   a_step_adjacent: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      $changed(power_mode_control[7:4]) |->
      (pmcs_chain_pos(power_mode_control[7:4]) -
       pmcs_chain_pos($past(power_mode_control[7:4])) == 3'h1) ||
      (pmcs_chain_pos($past(power_mode_control[7:4])) -
       pmcs_chain_pos(power_mode_control[7:4]) == 3'h1))
      else $error("mode jumped past a neighbour");

   a_bad_ignored: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      s_mode_write |=> $stable(power_mode_control))
      else $error("illegal step changed the register");

   a_osc_follow: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      ps_state == PS_RUN && next_ps_state == PS_RUN |=>
      fast_osc_on_o == $past(power_mode_control[PMCS_B_FAST_ON]) &&
      slow_osc_on_o == $past(power_mode_control[PMCS_B_SLOW_ON]))
      else $error("oscillator enable not following register");

   a_window_pass: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      ##1 idle_window_sel_o == $past(power_mode_control[2:0]))
      else $error("idle window not passed through");

   a_halt_option: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      ps_state == PS_RUN && halt_req && !opt_sync[1] |=>
      ps_state != PS_HALT)
      else $error("halt entered without option");

   a_halt_stops: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      ps_state == PS_HALT |->
      !fast_osc_on_o && !slow_osc_on_o && !idle_timer_run_o &&
      !core_run_o)
      else $error("activity during halt");

   a_idle_keeps: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      ps_state == PS_IDLE && $past(ps_state) == PS_IDLE |->
      idle_timer_run_o && !core_run_o &&
      fast_osc_on_o == $past(power_mode_control[PMCS_B_FAST_ON]))
      else $error("idle stopped the oscillator or timer");

   a_mode_decode: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      ##1 op_mode_o == ($past(power_mode_control[PMCS_B_CORE_SL])
         ? PMCS_M_LOW : $past(power_mode_control[PMCS_B_IT_SLOW])
         ? PMCS_M_DUAL : PMCS_M_HIGH))
      else $error("operating mode decode wrong");

   a_bus_answer: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      req && avs_waitrequest_o |=> !avs_waitrequest_o ##1
      avs_waitrequest_o)
      else $error("bus answer not one cycle");

   // power save exits, built from shared steps
   sequence s_idle_leave;
      ps_state == PS_IDLE && (idle_tick_i || wake_seen);
   endsequence

   sequence s_back_to_run;
      ps_state == PS_RUN && core_run_o;
   endsequence

   a_idle_leave: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      s_idle_leave |=> s_back_to_run)
      else $error("idle not left on tick or wake");

   a_halt_wake: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      ps_state == PS_HALT && wake_seen |=> s_back_to_run)
      else $error("halt not left on wake");

   a_idle_enter: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      ps_state == PS_RUN && idle_req && !(halt_req && opt_sync[1]) |=>
      ps_state == PS_IDLE && !core_run_o)
      else $error("idle request not taken");

   a_core_gates: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      !(core_fast_gate_o && core_slow_gate_o))
      else $error("both core gate outputs high");

   a_timer_source: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      ##1 idle_timer_slow_select_o ==
      ($past(power_mode_control[PMCS_B_IT_SLOW]) ||
       $past(power_mode_control[PMCS_B_CORE_SL])))
      else $error("idle timer source wrong");

   a_save_frozen: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      ps_state != PS_RUN && !wr_mode |=> $stable(power_mode_control))
      else $error("mode register moved in power save");
endmodule
`default_nettype wire

/* File: tb/pmcs_top_tb.sv */
// self-checking bench for the power mode clock selector top
// assumes pmcs_pkg and the design files are compiled first
`timescale 1ns/1ps
`default_nettype none
module pmcs_top_tb;
   import pmcs_pkg::*;

   typedef struct packed
   {
      logic [7:0] wdata;
      logic [7:0] stored;
      logic       idle;
   } pmcs_row_t;

   ////////////////////////////////////////////////////////////////////////
   // signals
   logic        clock_i;
   logic        rst_b;
   logic [3:0]  address;
   logic        rd;
   logic        wr;
   logic [31:0] wdata;
   logic [3:0]  byteen;
   logic [31:0] rdata;
   logic [31:0] bus_q;
   logic        wait_req;
   logic        halt_option;
   logic        wake;
   logic        idle_tick;
   logic        slow_on;
   logic        fast_on;
   logic        it_slow;
   logic        timer_run;
   logic [2:0]  window;
   logic        fast_gate;
   logic        slow_gate;
   logic        core_run;
   logic [1:0]  op_mode;
   int          mismatches;
   int          checks;

   // mode writes in order; each row is judged against the one before
   localparam pmcs_row_t ROWS[15] = '{
      '{8'he5, 8'h40, 1'b0}, '{8'hc1, 8'hc1, 1'b0}, '{8'h4f, 8'h47, 1'b1},
      '{8'hc2, 8'hc2, 1'b0}, '{8'hb2, 8'hc2, 1'b0}, '{8'he6, 8'he6, 1'b1},
      '{8'h76, 8'he6, 1'b0}, '{8'hf5, 8'hf5, 1'b0}, '{8'h40, 8'hf5, 1'b0},
      '{8'hb3, 8'hb3, 1'b1}, '{8'he0, 8'hb3, 1'b0}, '{8'hf4, 8'hf4, 1'b0},
      '{8'he4, 8'he4, 1'b0}, '{8'hc4, 8'hc4, 1'b0}, '{8'h44, 8'h44, 1'b0}};

   pmcs_top DUT
   (
      .clock_i                  (clock_i),
      .rst_b_i                  (rst_b),
      .avs_address_i            (address),
      .avs_read_i               (rd),
      .avs_write_i              (wr),
      .avs_writedata_i          (wdata),
      .avs_byteenable_i         (byteen),
      .avs_readdata_o           (rdata),
      .avs_waitrequest_o        (wait_req),
      .halt_option_i            (halt_option),
      .wake_i                   (wake),
      .idle_tick_i              (idle_tick),
      .slow_osc_on_o            (slow_on),
      .fast_osc_on_o            (fast_on),
      .idle_timer_slow_select_o (it_slow),
      .idle_timer_run_o         (timer_run),
      .idle_window_sel_o        (window),
      .core_fast_gate_o         (fast_gate),
      .core_slow_gate_o         (slow_gate),
      .core_run_o               (core_run),
      .op_mode_o                (op_mode)
   );

   ////////////////////////////////////////////////////////////////////////
   // clock, 100 ns period
   initial
   begin
      clock_i = 1'b0;
      forever #50 clock_i = ~clock_i;
   end

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // one bus cycle; entered just after a rising edge, leaves likewise
   task automatic bus_xfer(input logic is_wr, input logic [3:0] a,
                           input logic [31:0] d, input logic [3:0] bes,
                           output logic [31:0] q);
      int n;
      n = 0;
      q = '0;
      address <= a;
      wdata   <= d;
      byteen  <= bes;
      rd      <= ~is_wr;
      wr      <= is_wr;
      do
      begin
         @(posedge clock_i);
         n++;
      end
      while (wait_req !== 1'b0 && n < 20);
      if (wait_req !== 1'b0)
         chk("waitrequest", 32'h0, {31'h0, wait_req});
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      // spare edge so strobes never rise in the same step they fall
      @(posedge clock_i);
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus_xfer(1'b1, a, {24'h0, d}, 4'hf, q);
   endtask

   task automatic rd_chk(input string nm, input logic [3:0] a,
                         input logic [7:0] e);
      logic [31:0] q;
      bus_xfer(1'b0, a, 32'h0, 4'hf, q);
      chk(nm, {24'h0, e}, q);
   endtask

   // let the gate dead time and output lag pass, sample mid-cycle
   task automatic settle;
      repeat (PMCS_GAP_CYC + 5) @(posedge clock_i);
      @(negedge clock_i);
   endtask

   // outputs follow the stored mode byte
   task automatic out_chk(input logic [7:0] r);
      logic [1:0] m;
      m = r[4] ? PMCS_M_LOW : (r[5] ? PMCS_M_DUAL : PMCS_M_HIGH);
      settle();
      chk("slow_osc_on", {31'h0, r[7]}, {31'h0, slow_on});
      chk("fast_osc_on", {31'h0, r[6]}, {31'h0, fast_on});
      chk("idle_timer_slow", {31'h0, r[5]}, {31'h0, it_slow});
      chk("core_slow_gate", {31'h0, r[4]}, {31'h0, slow_gate});
      chk("core_fast_gate", {31'h0, ~r[4]}, {31'h0, fast_gate});
      chk("op_mode", {30'h0, m}, {30'h0, op_mode});
      chk("idle_window", {29'h0, r[2:0]}, {29'h0, window});
      chk("core_run", 32'h1, {31'h0, core_run});
      @(posedge clock_i);
   endtask

   // idle stops execution only; a window tick resumes it
   task automatic idle_chk(input logic [7:0] r);
      logic [1:0] m;
      m = r[4] ? PMCS_M_LOW : (r[5] ? PMCS_M_DUAL : PMCS_M_HIGH);
      wr_reg(PMCS_OFS_SAVE, 8'h02);
      settle();
      chk("idle core_run", 32'h0, {31'h0, core_run});
      chk("idle fast_osc", {31'h0, r[6]}, {31'h0, fast_on});
      chk("idle timer_run", 32'h1, {31'h0, timer_run});
      rd_chk("idle status", PMCS_OFS_SAVE, {3'h0, r[4], m, 2'h2});
      @(posedge clock_i);
      idle_tick <= 1'b1;
      @(posedge clock_i);
      idle_tick <= 1'b0;
      rd_chk("idle mode reg", PMCS_OFS_MODE, r);
      out_chk(r);
   endtask

   task automatic do_reset;
      rst_b <= 1'b0;
      repeat (4) @(posedge clock_i);
      rst_b <= 1'b1;
      @(posedge clock_i);
   endtask

   always @(negedge clock_i)
      if (rst_b === 1'b1 && fast_gate === 1'b1 && slow_gate === 1'b1)
         chk("gate overlap", 32'h0, 32'h1);

   // watchdog: the tests need roughly 400 cycles
   initial
   begin
      #(20000 * 100);
      mismatches++;
      $display("ERROR watchdog expected done seen timeout");
      give_verdict();
   end

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      rst_b = 1'b0;
      address = 4'h0;
      rd = 1'b0;
      wr = 1'b0;
      wdata = 32'h0;
      byteen = 4'h0;
      halt_option = 1'b0;
      wake = 1'b0;
      idle_tick = 1'b0;
      mismatches = 0;
      checks = 0;
      do_reset();
      rd_chk("reset mode reg", PMCS_OFS_MODE, PMCS_MODE_RST);
      out_chk(8'h40);
      // chain walk, one row per write
      // oscillator on before use; dual left in two writes
      // slow oscillator pins lie outside the block, none driven
      foreach (ROWS[i])
      begin
         wr_reg(PMCS_OFS_MODE, ROWS[i].wdata);
         rd_chk("mode reg", PMCS_OFS_MODE, ROWS[i].stored);
         out_chk(ROWS[i].stored);
         if (ROWS[i].idle)
            idle_chk(ROWS[i].stored);
      end
      // byte 0 disabled, unmapped place
      bus_xfer(1'b1, PMCS_OFS_MODE, 32'hc4, 4'he, bus_q);
      rd_chk("byteen mode reg", PMCS_OFS_MODE, 8'h44);
      wr_reg(4'h8, 8'hff);
      rd_chk("unmapped", 4'h8, 8'h00);
      rd_chk("mode after unmapped", PMCS_OFS_MODE, 8'h44);
      // halt refused without the option bit
      wr_reg(PMCS_OFS_SAVE, 8'h01);
      out_chk(8'h44);
      halt_option <= 1'b1;
      repeat (4) @(posedge clock_i);
      wr_reg(PMCS_OFS_SAVE, 8'h01);
      settle();
      chk("halt core_run", 32'h0, {31'h0, core_run});
      chk("halt fast_osc", 32'h0, {31'h0, fast_on});
      chk("halt timer_run", 32'h0, {31'h0, timer_run});
      chk("halt fast_gate", 32'h0, {31'h0, fast_gate});
      @(posedge clock_i);
      rd_chk("halt mode reg", PMCS_OFS_MODE, 8'h44);
      rd_chk("halt status", PMCS_OFS_SAVE, 8'h41);
      wake <= 1'b1;
      repeat (4) @(posedge clock_i);
      wake <= 1'b0;
      out_chk(8'h44);
      rd_chk("wake status", PMCS_OFS_SAVE, 8'h40);
      wr_reg(PMCS_OFS_MODE, 8'hc5);
      wr_reg(PMCS_OFS_MODE, 8'he5);
      out_chk(8'he5);
      do_reset();
      rd_chk("rereset mode reg", PMCS_OFS_MODE, 8'h40);
      out_chk(8'h40);
      give_verdict();
   end
endmodule
`default_nettype wire
